//--- logic/tq_dev.sv
// transmit queue manager: packet memory, frame queueing, free space and interrupts
// Function
// - 6KB transmit, 12KB receive packet memory; the receive memory is only sized here, with no memory or path
// - frame: control word, byte count, data
// - big endian swaps header word bytes
// - append CRC only when control bit 1
// - frames stack back to back until full
// - status follows frame now sent to MAC
// - control bit 15 raises completion interrupt
// - frame tag copied into status register
// - host writes exact nonzero byte count
// - addresses and type sent unchanged
// - control bits: flow, pad, CRC, enable
// - control bits 8-5 enable checksum generation
// - free memory reported in bytes, 13 bits
// - manual enqueue sends one, then self-clears
// - host waits for enqueue bit clear
// - space request raises status bit 6
// - auto enqueue queues each frame prepared while it is set
// - session bit opens data port access; here it gates data port writes only, reads are not gated
// - pointer bit 14 enables auto increment
// - enable bits 14 and 6 gate interrupts
// - writing one clears status bits
// - host programs next size in dwords
// - pointer bit 11 selects byte order
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module tq_dev (
    input wire logic clk,
    input wire logic rstn,
    tq_if.dev bus,
    input wire logic endian_strap,
    output logic [7:0] mac_data,
    output logic mac_valid,
    output logic mac_last,
    input wire logic mac_ready,
    output logic mac_crc_en,
    output logic mac_pad_en,
    output logic mac_flow_en,
    output logic [3:0] mac_csum_en
);
    import tq_pkg::*;

    // receive memory is only sized here; there is no receive memory or path
    localparam int unsigned RX_BYTES = TQ_RX_MEM_BYTES;

    logic [15:0] mem [0:TQ_TX_MEM_WORDS-1];

    logic [15:0] txc_q, txc_d, ier_q, ier_d, isr_q, isr_d, nfs_q, nfs_d, rdata_q, rdata_d;
    logic [2:0] tqc_q, tqc_d;
    logic sess_q, sess_d, inc_q, inc_d, big_q, big_d, mbusy_q, mbusy_d;
    logic [11:0] wp_q, wp_d, widx_q, widx_d;
    logic [10:0] plen_q, plen_d;
    logic [7:0] pend_q, pend_d, queued_q, queued_d;
    logic [12:0] free_q, free_d;
    tq_tx_state_t st_q, st_d;
    logic [11:0] rp_q, rp_d, fs_q, fs_d;
    logic [10:0] flen_q, flen_d, bcnt_q, bcnt_d;
    logic fic_q, fic_d, mv_q, mv_d, ml_q, ml_d;
    logic [7:0] md_q, md_d;
    logic [15:0] stat_q, stat_d;
    logic tx_done, big, wr_data, new_word;
    logic [15:0] hw, ww;

    function automatic logic [11:0] wrap(input logic [12:0] a);
        logic [12:0] lim;
        lim = {1'b0, TQ_TX_MEM_WORDS};
        return (a >= lim) ? 12'(a - lim) : a[11:0];
    endfunction : wrap

    // header and data padded so every frame ends on a dword boundary
    function automatic logic [11:0] fr_words(input logic [10:0] n);
        logic [11:0] q;
        q = ({1'b0, n} + 12'h003) >> 2;
        return 12'h002 + (q << 1);
    endfunction : fr_words

    function automatic logic [15:0] hdr(input logic [15:0] w, input logic b);
        return b ? {w[7:0], w[15:8]} : w;
    endfunction : hdr

    assign big = endian_strap | big_q;
    assign wr_data = bus.wr && (bus.addr == TQ_DATA_PORT) && sess_q;
    assign new_word = wr_data && inc_q;
    assign ww = hdr(bus.wdata, big);
    assign hw = hdr(mem[rp_q], big);

    always_ff @(posedge clk) begin
        if (wr_data) begin
            mem[wp_q] <= bus.wdata;
        end
    end

    // register file, frame preparation and queue bookkeeping
    always_comb begin
        logic [10:0] len;
        logic done_prep, move_man;
        logic [7:0] q_inc;
        len = plen_q;
        done_prep = 1'b0;
        move_man = 1'b0;
        q_inc = 8'h00;
        txc_d = txc_q;
        tqc_d = tqc_q;
        sess_d = sess_q;
        inc_d = inc_q;
        big_d = big_q;
        ier_d = ier_q;
        nfs_d = nfs_q;
        wp_d = wp_q;
        widx_d = widx_q;
        plen_d = plen_q;
        pend_d = pend_q;
        mbusy_d = mbusy_q;
        free_d = free_q;
        isr_d = isr_q;
        if (bus.wr) begin
            unique case (bus.addr)
                TQ_TX_CONTROL: txc_d = bus.wdata & TQ_TXC_MASK;
                TQ_TX_QUEUE_COMMAND: begin
                    tqc_d[TQ_TQC_AUTO] = bus.wdata[TQ_TQC_AUTO];
                    if (bus.wdata[TQ_TQC_MANUAL]) tqc_d[TQ_TQC_MANUAL] = 1'b1;
                    if (bus.wdata[TQ_TQC_SPACE]) tqc_d[TQ_TQC_SPACE] = 1'b1;
                end
                TQ_RX_QUEUE_COMMAND: sess_d = bus.wdata[TQ_RQC_SESSION];
                TQ_TX_DATA_POINTER: inc_d = bus.wdata[TQ_DP_AUTO_INC];
                TQ_RX_DATA_POINTER: big_d = bus.wdata[TQ_RDP_BIG_ENDIAN];
                TQ_INTERRUPT_ENABLE: ier_d = bus.wdata;
                TQ_INTERRUPT_STATUS: isr_d = isr_q & ~bus.wdata;
                TQ_TX_NEXT_SIZE_REQUEST: nfs_d = bus.wdata;
                default: ;
            endcase
        end
        if (new_word) begin
            wp_d = wrap({1'b0, wp_q} + 13'h0001);
            widx_d = widx_q + 12'h001;
            if (widx_q == 12'h001) begin
                len = ww[TQ_LEN_MSB:0];
                plen_d = len;
            end
            if (widx_q != 12'h000 && widx_q + 12'h001 == fr_words(len)) begin
                done_prep = 1'b1;
                widx_d = 12'h000;
            end
        end
        // manual mode moves one prepared frame and holds the bit until it is sent
        if (tqc_q[TQ_TQC_MANUAL] && !mbusy_q && pend_q != 8'h00) begin
            move_man = 1'b1;
            mbusy_d = 1'b1;
        end
        if (tqc_q[TQ_TQC_AUTO] && done_prep) begin
            q_inc = q_inc + 8'h01;
        end else if (done_prep) begin
            pend_d = pend_d + 8'h01;
        end
        if (move_man) begin
            pend_d = pend_d - 8'h01;
            q_inc = q_inc + 8'h01;
        end
        queued_d = queued_q + q_inc - {7'h00, tx_done};
        free_d = free_q - (new_word ? 13'h0002 : 13'h0000);
        if (tx_done) begin
            free_d = free_d + {fr_words(flen_q), 1'b0};
            if (mbusy_q) begin
                mbusy_d = 1'b0;
                tqc_d[TQ_TQC_MANUAL] = 1'b0;
            end
            if (fic_q) isr_d[TQ_IRQ_TX_DONE] = 1'b1;
        end
        if (tqc_q[TQ_TQC_SPACE] && {5'h00, free_q} >= {nfs_q, 2'b00}) begin
            isr_d[TQ_IRQ_TX_SPACE] = 1'b1;
            tqc_d[TQ_TQC_SPACE] = 1'b0;
        end
        rdata_d = rdata_q;
        if (bus.rd) begin
            unique case (bus.addr)
                TQ_TX_CONTROL: rdata_d = txc_q;
                TQ_TX_FRAME_STATUS: rdata_d = stat_q;
                TQ_TX_FREE_MEMORY: rdata_d = {3'h0, free_q};
                TQ_TX_QUEUE_COMMAND: rdata_d = {13'h0000, tqc_q};
                TQ_RX_QUEUE_COMMAND: rdata_d = {12'h000, sess_q, 3'h0};
                TQ_TX_DATA_POINTER: rdata_d = {1'b0, inc_q, 2'h0, wp_q};
                TQ_RX_DATA_POINTER: rdata_d = {4'h0, big, 11'h000};
                TQ_INTERRUPT_ENABLE: rdata_d = ier_q;
                TQ_INTERRUPT_STATUS: rdata_d = isr_q;
                TQ_TX_NEXT_SIZE_REQUEST: rdata_d = nfs_q;
                TQ_DATA_PORT: rdata_d = mem[wp_q];
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txc_q <= 16'h0000;
            tqc_q <= 3'h0;
            sess_q <= 1'b0;
            inc_q <= 1'b0;
            big_q <= 1'b0;
            ier_q <= 16'h0000;
            isr_q <= 16'h0000;
            nfs_q <= 16'h0000;
            wp_q <= 12'h000;
            widx_q <= 12'h000;
            plen_q <= 11'h000;
            pend_q <= 8'h00;
            queued_q <= 8'h00;
            mbusy_q <= 1'b0;
            free_q <= TQ_FREE_RST;
            rdata_q <= 16'h0000;
        end else begin
            txc_q <= txc_d;
            tqc_q <= tqc_d;
            sess_q <= sess_d;
            inc_q <= inc_d;
            big_q <= big_d;
            ier_q <= ier_d;
            isr_q <= isr_d;
            nfs_q <= nfs_d;
            wp_q <= wp_d;
            widx_q <= widx_d;
            plen_q <= plen_d;
            pend_q <= pend_d;
            queued_q <= queued_d;
            mbusy_q <= mbusy_d;
            free_q <= free_d;
            rdata_q <= rdata_d;
        end
    end

    // transmit engine: walks queued frames and hands bytes to the MAC
    always_comb begin
        st_d = st_q;
        rp_d = rp_q;
        fs_d = fs_q;
        flen_d = flen_q;
        bcnt_d = bcnt_q;
        fic_d = fic_q;
        stat_d = stat_q;
        md_d = md_q;
        ml_d = ml_q;
        mv_d = mac_ready ? 1'b0 : mv_q;
        tx_done = 1'b0;
        unique case (st_q)
            TQ_TX_IDLE: begin
                if (queued_q != 8'h00 && txc_q[TQ_TXC_ENABLE]) begin
                    fs_d = rp_q;
                    st_d = TQ_TX_CTRL;
                end
            end
            TQ_TX_CTRL: begin
                fic_d = hw[TQ_CW_IRQ_ON_COMPLETION];
                stat_d = {10'h000, hw[TQ_CW_TAG_MSB:0]};
                rp_d = wrap({1'b0, rp_q} + 13'h0001);
                st_d = TQ_TX_LEN;
            end
            TQ_TX_LEN: begin
                flen_d = hw[TQ_LEN_MSB:0];
                bcnt_d = 11'h000;
                rp_d = wrap({1'b0, rp_q} + 13'h0001);
                st_d = TQ_TX_DATA;
            end
            TQ_TX_DATA: begin
                if (!mv_q || mac_ready) begin
                    // payload bytes pass untouched, addresses and type included
                    md_d = bcnt_q[0] ? mem[rp_q][15:8] : mem[rp_q][7:0];
                    mv_d = 1'b1;
                    ml_d = (bcnt_q + 11'h001 == flen_q);
                    bcnt_d = bcnt_q + 11'h001;
                    if (bcnt_q[0]) rp_d = wrap({1'b0, rp_q} + 13'h0001);
                    if (bcnt_q + 11'h001 == flen_q) st_d = TQ_TX_DONE;
                end
            end
            TQ_TX_DONE: begin
                if (!mv_q || mac_ready) begin
                    ml_d = 1'b0;
                    tx_done = 1'b1;
                    stat_d[TQ_STAT_SENT] = 1'b1;
                    rp_d = wrap({1'b0, fs_q} + {1'b0, fr_words(flen_q)});
                    st_d = TQ_TX_IDLE;
                end
            end
            default: st_d = TQ_TX_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= TQ_TX_IDLE;
            rp_q <= 12'h000;
            fs_q <= 12'h000;
            flen_q <= 11'h000;
            bcnt_q <= 11'h000;
            fic_q <= 1'b0;
            stat_q <= 16'h0000;
            md_q <= 8'h00;
            mv_q <= 1'b0;
            ml_q <= 1'b0;
        end else begin
            st_q <= st_d;
            rp_q <= rp_d;
            fs_q <= fs_d;
            flen_q <= flen_d;
            bcnt_q <= bcnt_d;
            fic_q <= fic_d;
            stat_q <= stat_d;
            md_q <= md_d;
            mv_q <= mv_d;
            ml_q <= ml_d;
        end
    end

    assign mac_data = md_q;
    assign mac_valid = mv_q;
    assign mac_last = ml_q;
    assign mac_crc_en = txc_q[TQ_TXC_CRC];
    assign mac_pad_en = txc_q[TQ_TXC_PAD];
    assign mac_flow_en = txc_q[TQ_TXC_FLOW];
    assign mac_csum_en = txc_q[TQ_TXC_CSUM_LSB +: 4];
    assign bus.rdata = rdata_q;
    assign bus.irq_n = ~|(ier_q & isr_q);
endmodule : tq_dev

//--- logic/tq_pkg.sv
// shared constants and types for the transmit queue manager and its host controller
package tq_pkg;
    // device register offsets on the parallel register bus
    localparam logic [7:0] TQ_TX_CONTROL = 8'h70;
    localparam logic [7:0] TQ_TX_FRAME_STATUS = 8'h72;
    localparam logic [7:0] TQ_TX_FREE_MEMORY = 8'h78;
    localparam logic [7:0] TQ_TX_QUEUE_COMMAND = 8'h80;
    localparam logic [7:0] TQ_RX_QUEUE_COMMAND = 8'h82;
    localparam logic [7:0] TQ_TX_DATA_POINTER = 8'h84;
    localparam logic [7:0] TQ_RX_DATA_POINTER = 8'h86;
    localparam logic [7:0] TQ_INTERRUPT_ENABLE = 8'h90;
    localparam logic [7:0] TQ_INTERRUPT_STATUS = 8'h92;
    localparam logic [7:0] TQ_TX_NEXT_SIZE_REQUEST = 8'h9e;
    localparam logic [7:0] TQ_DATA_PORT = 8'hd0;
    // packet memories in bytes, the transmit one also in 16-bit words
    localparam int unsigned TQ_TX_MEM_BYTES = 6144;
    localparam int unsigned TQ_RX_MEM_BYTES = 12288;
    localparam logic [11:0] TQ_TX_MEM_WORDS = 12'hc00;
    localparam logic [12:0] TQ_FREE_RST = 13'h1800;
    localparam logic [10:0] TQ_MAX_PAYLOAD = 11'h7d0;
    // field positions
    localparam int TQ_CW_IRQ_ON_COMPLETION = 15;
    localparam int TQ_CW_TAG_MSB = 5;
    localparam int TQ_LEN_MSB = 10;
    localparam int TQ_TXC_ENABLE = 0;
    localparam int TQ_TXC_CRC = 1;
    localparam int TQ_TXC_PAD = 2;
    localparam int TQ_TXC_FLOW = 3;
    localparam int TQ_TXC_CSUM_LSB = 5;
    localparam logic [15:0] TQ_TXC_MASK = 16'h01ef;
    localparam int TQ_TQC_MANUAL = 0;
    localparam int TQ_TQC_SPACE = 1;
    localparam int TQ_TQC_AUTO = 2;
    localparam int TQ_RQC_SESSION = 3;
    localparam int TQ_DP_AUTO_INC = 14;
    localparam int TQ_RDP_BIG_ENDIAN = 11;
    localparam int TQ_IRQ_TX_DONE = 14;
    localparam int TQ_IRQ_TX_SPACE = 6;
    localparam int TQ_STAT_SENT = 15;
    // host controller registers on AXI4-Lite (byte addresses)
    localparam logic [7:0] TQ_H_CMD = 8'h00;
    localparam logic [7:0] TQ_H_WDATA = 8'h04;
    localparam logic [7:0] TQ_H_STATUS = 8'h08;
    localparam int TQ_H_CMD_WRITE = 8;
    localparam int TQ_H_ST_BUSY = 16;
    localparam int TQ_H_ST_IRQ = 17;
    localparam logic [1:0] TQ_RESP_OKAY = 2'h0;
    localparam logic [1:0] TQ_RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        TQ_TX_IDLE = 5'b00001,
        TQ_TX_CTRL = 5'b00010,
        TQ_TX_LEN = 5'b00100,
        TQ_TX_DATA = 5'b01000,
        TQ_TX_DONE = 5'b10000
    } tq_tx_state_t;

    typedef enum logic [2:0] {
        TQ_H_IDLE = 3'b001,
        TQ_H_ISSUE = 3'b010,
        TQ_H_CAPTURE = 3'b100
    } tq_host_state_t;
endpackage : tq_pkg

//--- logic/tq_if.sv
// register and data port bus between the host controller and the queue manager
`timescale 1ns/1ps
interface tq_if;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic irq_n;

    modport dev (
        input addr,
        input wr,
        input rd,
        input wdata,
        output rdata,
        output irq_n
    );

    modport host (
        output addr,
        output wr,
        output rd,
        output wdata,
        input rdata,
        input irq_n
    );
endinterface : tq_if

//--- logic/tq_host.sv
// host controller: AXI4-Lite command registers driving the queue manager register bus
`timescale 1ns/1ps
module tq_host (
    input wire logic clk,
    input wire logic rstn,
    tq_if.host bus,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import tq_pkg::*;

    logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0] awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [1:0] br_q, br_d, rr_q, rr_d;
    logic [15:0] hwd_q, hwd_d, res_q, res_d, bwd_q, bwd_d;
    logic [7:0] ba_q, ba_d;
    logic bwr_q, bwr_d, brd_q, brd_d;
    tq_host_state_t st_q, st_d;

    assign s_axi_awready = !aw_q && !bv_q;
    assign s_axi_wready = !w_q && !bv_q;
    assign s_axi_arready = !rv_q;

    always_comb begin
        aw_d = aw_q;
        w_d = w_q;
        awa_d = awa_q;
        wd_d = wd_q;
        bv_d = bv_q;
        br_d = br_q;
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        hwd_d = hwd_q;
        res_d = res_q;
        ba_d = ba_q;
        bwd_d = bwd_q;
        bwr_d = 1'b0;
        brd_d = 1'b0;
        st_d = st_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_d = 1'b1;
            wd_d = s_axi_wdata;
        end
        if (s_axi_bvalid && s_axi_bready) bv_d = 1'b0;
        // the write commits only once both address and data are held
        if (aw_q && w_q && !bv_q) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
            br_d = TQ_RESP_OKAY;
            unique case ({awa_q[7:2], 2'b00})
                TQ_H_CMD: begin
                    // a command while one is in flight is dropped, not queued
                    if (st_q == TQ_H_IDLE) begin
                        ba_d = wd_q[7:0];
                        bwd_d = hwd_q;
                        bwr_d = wd_q[TQ_H_CMD_WRITE];
                        brd_d = !wd_q[TQ_H_CMD_WRITE];
                        st_d = TQ_H_ISSUE;
                    end
                end
                TQ_H_WDATA: hwd_d = wd_q[15:0];
                TQ_H_STATUS: ;
                default: br_d = TQ_RESP_SLVERR;
            endcase
        end
        unique case (st_q)
            TQ_H_IDLE: ;
            TQ_H_ISSUE: st_d = TQ_H_CAPTURE;
            TQ_H_CAPTURE: begin
                res_d = bus.rdata;
                st_d = TQ_H_IDLE;
            end
            default: st_d = TQ_H_IDLE;
        endcase
        if (s_axi_rvalid && s_axi_rready) rv_d = 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            rv_d = 1'b1;
            rr_d = TQ_RESP_OKAY;
            unique case ({s_axi_araddr[7:2], 2'b00})
                TQ_H_CMD: rd_d = {23'h000000, bwr_q, ba_q};
                TQ_H_WDATA: rd_d = {16'h0000, hwd_q};
                TQ_H_STATUS: rd_d = {14'h0000, !bus.irq_n, st_q != TQ_H_IDLE, res_q};
                default: begin
                    rd_d = 32'h00000000;
                    rr_d = TQ_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h00000000;
            bv_q <= 1'b0;
            br_q <= 2'h0;
            rv_q <= 1'b0;
            rd_q <= 32'h00000000;
            rr_q <= 2'h0;
            hwd_q <= 16'h0000;
            res_q <= 16'h0000;
            ba_q <= 8'h00;
            bwd_q <= 16'h0000;
            bwr_q <= 1'b0;
            brd_q <= 1'b0;
            st_q <= TQ_H_IDLE;
        end else begin
            aw_q <= aw_d;
            w_q <= w_d;
            awa_q <= awa_d;
            wd_q <= wd_d;
            bv_q <= bv_d;
            br_q <= br_d;
            rv_q <= rv_d;
            rd_q <= rd_d;
            rr_q <= rr_d;
            hwd_q <= hwd_d;
            res_q <= res_d;
            ba_q <= ba_d;
            bwd_q <= bwd_d;
            bwr_q <= bwr_d;
            brd_q <= brd_d;
            st_q <= st_d;
        end
    end

    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = br_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rd_q;
    assign s_axi_rresp = rr_q;
    assign bus.addr = ba_q;
    assign bus.wr = bwr_q;
    assign bus.rd = brd_q;
    assign bus.wdata = bwd_q;
endmodule : tq_host

//--- tb/tq_monitor.sv
// concurrent checks on the register bus between the host controller and the queue manager
`timescale 1ns/1ps
module tq_monitor
    import tq_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic irq_n
);
    logic [15:0] txc_q, txc_d, ien_q, ien_d;

    // shadows of host writes, so readback and interrupt gating can be judged
    always_comb begin
        txc_d = (wr && addr == TQ_TX_CONTROL) ? wdata : txc_q;
        ien_d = (wr && addr == TQ_INTERRUPT_ENABLE) ? wdata : ien_q;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txc_q <= 16'h0000;
            ien_q <= 16'h0000;
        end else begin
            txc_q <= txc_d;
            ien_q <= ien_d;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_free_bound: assert property (rd && addr == TQ_TX_FREE_MEMORY |=> rdata <= 16'h1800)
        else $error("free memory above capacity");
    chk_free_even: assert property (rd && addr == TQ_TX_FREE_MEMORY |=> !rdata[0])
        else $error("free memory count odd");
    chk_status_resv: assert property (rd && addr == TQ_TX_FRAME_STATUS |=> rdata[14:6] == 9'h000)
        else $error("status reserved bits set");
    chk_txc_readback: assert property (rd && addr == TQ_TX_CONTROL |-> ##1 rdata == (txc_q & TQ_TXC_MASK))
        else $error("tx control readback wrong");
    chk_irq_gated: assert property ((ien_q & 16'h4040) == 16'h0000 |-> irq_n)
        else $error("interrupt while all masked");
    chk_clear_all: assert property (wr && addr == TQ_INTERRUPT_STATUS && wdata == 16'hffff |=> irq_n)
        else $error("interrupt not cleared");
    chk_rdata_hold: assert property (!rd |=> $stable(rdata))
        else $error("read data moved without read");
    chk_unmapped_zero: assert property (rd && addr == 8'h10 |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_strobe_excl: assert property (!(wr && rd))
        else $error("read and write together");
endmodule : tq_monitor

//--- tb/tq_tb_top.sv
// self-checking bench: AXI4-Lite host controller facing the queue manager
`timescale 1ns/1ps
module tq_tb_top;
    import tq_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, endian_strap = 1'b0, mac_ready = 1'b0;
    logic [7:0] mac_data;
    logic mac_valid, mac_last, mac_crc_en, mac_pad_en, mac_flow_en;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb = 4'hf, mac_csum_en;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [7:0] got[$];
    logic [15:0] fw [0:5] = '{16'h802a, 16'h0005, 16'h2211, 16'h4433, 16'h0055, 16'h0000};
    int bad_count = 0, comparisons = 0, i, lastn;

    tq_if bus();
    tq_dev u_tq_dev (.clk, .rstn, .bus(bus.dev), .endian_strap, .mac_data, .mac_valid, .mac_last,
        .mac_ready, .mac_crc_en, .mac_pad_en, .mac_flow_en, .mac_csum_en);
    tq_host u_tq_host (.clk, .rstn, .bus(bus.host), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    tq_monitor u_tq_monitor (.clk, .rstn, .addr(bus.addr), .wr(bus.wr), .rd(bus.rd),
        .wdata(bus.wdata), .rdata(bus.rdata), .irq_n(bus.irq_n));

    always #4 clk = ~clk;

    // mac stalls every other cycle so each byte waits
    always @(posedge clk) begin
        mac_ready <= ~mac_ready;
        if (mac_valid && mac_ready) got.push_back(mac_data);
        if (mac_valid && mac_ready && mac_last) lastn = got.size();
    end

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic hang(input int n);
        if (n >= 60) begin
            bad_count++;
            finish_test();
        end
    endtask : hang

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic aw, w, b;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(negedge clk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) break;
        end
        hang(n);
        chk({14'h0, rsp}, {14'h0, er});
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
        int n;
        logic ar, r;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 60; n++) begin
            @(negedge clk);
            ar = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid;
            rsp = s_axi_rresp;
            rv = s_axi_rdata;
            @(posedge clk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (r) break;
        end
        hang(n);
        chk({14'h0, rsp}, {14'h0, er});
    endtask : axi_rd

    // one device access through the controller, polled until it is no longer busy
    task automatic dev(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        if (w) axi_wr(TQ_H_WDATA, {16'h0000, d}, TQ_RESP_OKAY);
        axi_wr(TQ_H_CMD, {23'h0, w, a}, TQ_RESP_OKAY);
        for (n = 0; n < 60; n++) begin
            axi_rd(TQ_H_STATUS, TQ_RESP_OKAY);
            if (rv[TQ_H_ST_BUSY] === 1'b0) break;
        end
        hang(n);
    endtask : dev

    task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
        dev(1'b0, a, 16'h0000);
        chk(rv[15:0], e);
    endtask : rdchk

    task automatic irqchk(input logic e);
        axi_rd(TQ_H_STATUS, TQ_RESP_OKAY);
        chk({15'h0, rv[TQ_H_ST_IRQ]}, {15'h0, e});
    endtask : irqchk

    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        axi_rd(8'h0c, TQ_RESP_SLVERR);
        axi_wr(8'h0c, 32'h0, TQ_RESP_SLVERR);
        rdchk(TQ_TX_FREE_MEMORY, 16'h1800);
        rdchk(8'h10, 16'h0000);
        dev(1'b1, TQ_TX_CONTROL, 16'hffff);
        rdchk(TQ_TX_CONTROL, 16'h01ef);
        chk({9'h0, mac_csum_en, mac_flow_en, mac_pad_en, mac_crc_en}, 16'h007f);
        dev(1'b1, TQ_TX_CONTROL, 16'h0001);
        chk({13'h0, mac_flow_en, mac_pad_en, mac_crc_en}, 16'h0000);
        $display("test 1 end");
        dev(1'b1, TQ_RX_QUEUE_COMMAND, 16'h0008);
        dev(1'b1, TQ_TX_DATA_POINTER, 16'h4000);
        for (i = 0; i < 6; i++) dev(1'b1, TQ_DATA_PORT, fw[i]);
        rdchk(TQ_TX_FREE_MEMORY, 16'h17f4);
        dev(1'b1, TQ_INTERRUPT_ENABLE, 16'h4000);
        dev(1'b1, TQ_TX_QUEUE_COMMAND, 16'h0001);
        for (i = 0; i < 60; i++) begin
            dev(1'b0, TQ_TX_QUEUE_COMMAND, 16'h0000);
            if (rv[TQ_TQC_MANUAL] === 1'b0) break;
        end
        hang(i);
        chk(16'(got.size()), 16'd5);
        chk(16'(lastn), 16'd5);
        for (i = 0; i < 5; i++) chk({8'h00, got[i]}, 16'(8'h11 * (i + 1)));
        rdchk(TQ_TX_FRAME_STATUS, 16'h802a);
        rdchk(TQ_TX_FREE_MEMORY, 16'h1800);
        irqchk(1'b1);
        dev(1'b1, TQ_INTERRUPT_STATUS, 16'hffff);
        irqchk(1'b0);
        $display("test 2 end");
        endian_strap <= 1'b1;
        got.delete();
        dev(1'b1, TQ_TX_QUEUE_COMMAND, 16'h0004);
        dev(1'b1, TQ_DATA_PORT, 16'h1500);
        dev(1'b1, TQ_DATA_PORT, 16'h0200);
        dev(1'b1, TQ_DATA_PORT, 16'hbbaa);
        dev(1'b1, TQ_DATA_PORT, 16'h0000);
        for (i = 0; i < 60 && got.size() < 2; i++) @(posedge clk);
        hang(i);
        chk({got[1], got[0]}, 16'hbbaa);
        chk(16'(lastn), 16'd2);
        rdchk(TQ_TX_FRAME_STATUS, 16'h8015);
        irqchk(1'b0);
        $display("test 3 end");
        dev(1'b1, TQ_TX_NEXT_SIZE_REQUEST, 16'h0600);
        dev(1'b1, TQ_INTERRUPT_ENABLE, 16'h0040);
        dev(1'b1, TQ_TX_QUEUE_COMMAND, 16'h0006);
        irqchk(1'b1);
        rdchk(TQ_INTERRUPT_STATUS, 16'h0040);
        rdchk(TQ_TX_QUEUE_COMMAND, 16'h0004);
        dev(1'b1, TQ_INTERRUPT_ENABLE, 16'h0000);
        irqchk(1'b0);
        dev(1'b1, TQ_INTERRUPT_STATUS, 16'h0040);
        rdchk(TQ_INTERRUPT_STATUS, 16'h0000);
        $display("test 4 end");
        finish_test();
    end
endmodule : tq_tb_top
